// ===== hdl/pbm_pkg.sv
// constants, field layouts and carrier types for the 100 Mb/s bypass datapath
// assumes a 10 MHz core clock and a link bit clock sampled on that clock
package pbm_pkg;
    // management space
    localparam int MGMT_ADDR_W = 5;
    localparam int REG_W = 16;
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_LOOPBACK_BYPASS = 5'h18;
    localparam int CTRL_RESET_BIT = 15;
    localparam int CTRL_SPEED_BIT = 13;
    localparam int CTRL_AN_BIT = 12;
    localparam int LBE_SYM_BYPASS_BIT = 14;
    localparam int LBE_SCR_BYPASS_BIT = 13;
    localparam int LBE_ALIGN_BYPASS_BIT = 12;
    localparam logic [15:0] CTRL_RESET_VAL = 16'h3000;
    localparam logic [15:0] LBE_RESET_VAL = 16'h0000;

    // strap capture window
    localparam int CLK_PERIOD_NS = 100;
    localparam int STRAP_LATCH_NS = 2000;
    localparam int STRAP_CYCLES_INT = (STRAP_LATCH_NS / CLK_PERIOD_NS) < 1 ? 1 : (STRAP_LATCH_NS / CLK_PERIOD_NS);
    localparam logic [4:0] STRAP_CYCLES = 5'(STRAP_CYCLES_INT);
    localparam logic [4:0] LATCH_LAST = 5'h01;

    // input synchroniser bit positions
    localparam int SYNC_W = 7;
    localparam int SYNC_LCLK = 0;
    localparam int SYNC_LRXD = 1;
    localparam int SYNC_SYM = 2;
    localparam int SYNC_SCR = 3;
    localparam int SYNC_ALIGN = 4;
    localparam int SYNC_REP = 5;
    localparam int SYNC_LOW_POWER_STRAP = 6;

    // code-groups, sent most significant bit first
    localparam int SYM_W = 5;
    localparam logic [2:0] SYM_LAST = 3'h4;
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    localparam logic [4:0] SYM_T = 5'h0d;
    localparam logic [4:0] SYM_R = 5'h07;
    localparam logic [4:0] SYM_IDLE = 5'h1f;
    localparam logic [4:0] SYM_HALT = 5'h04;
    localparam logic [4:0] SYM_ZERO = 5'h00;
    localparam logic [3:0] PREAMBLE_NIB = 4'h5;
    localparam logic [15:0][4:0] ENC_TABLE = {
        5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};

    // self-synchronising stream cipher, x^11 + x^9 + 1
    localparam int SCR_LEN = 11;
    localparam int SCR_TAP_A = 8;
    localparam int SCR_TAP_B = 10;

    typedef enum logic [1:0] {TXS_IDLE, TXS_K, TXS_DATA, TXS_R} pbm_tx_state_e;

    typedef struct packed {
        logic tx_en;
        logic tx_er;
        logic [3:0] txd;
    } pbm_mii_tx_s;

    typedef struct packed {
        logic rx_dv;
        logic rx_er;
        logic [3:0] rxd;
        logic crs;
        logic col;
    } pbm_mii_rx_s;

    typedef struct packed {
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic lclk_prev;
        logic [15:0] ctrl;
        logic [15:0] lbe;
        logic [4:0] latch_cnt;
        logic repeater;
        logic low_power;
        logic [15:0] rdata;
        logic [2:0] tx_cnt;
        logic [4:0] tx_sh;
        logic [SCR_LEN-1:0] tx_scr;
        logic txd_bit;
        pbm_tx_state_e tx_st;
        logic tx_strobe;
        logic [2:0] rx_cnt;
        logic [8:0] rx_hist;
        logic [SCR_LEN-1:0] rx_scr;
        logic [4:0] rx_pend;
        logic rx_active;
        logic rx_tail;
        logic rx_strobe;
        pbm_mii_rx_s rx_out;
    } pbm_state_s;
endpackage

// ===== hdl/pbm_symbol_decode.sv
// 5-bit data code-group to nibble lookup
// assumes code-groups are already aligned and descrambled
`timescale 1ns/1ps
module pbm_symbol_decode (
    input wire logic [4:0] sym,
    output logic [3:0] nib,
    output logic valid
);
    logic [15:0] match;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_match
            assign match[i] = (sym == pbm_pkg::ENC_TABLE[i]);
        end
    endgenerate

    always_comb begin
        nib = 4'h0;
        for (int k = 0; k < 16; k++) begin
            if (match[k]) begin
                nib = 4'(k);
            end
        end
        valid = |match;
    end
endmodule

// ===== hdl/pbm_datapath.sv
// 100 Mb/s symbol datapath with translational, transparent and serializer-only modes
// assumes MII inputs on this clock; link clock, link data and straps arrive asynchronously
//
// How it works
// - default mode keeps every conditioning stage active.
// - symbol strap or bit 14 skips 4B/5B.
// - transparent fifth bit rides on error lines.
// - transparent keeps translational MII strobe timing.
// - transparent receive passes J/K and T/R intact.
// - data valid unchanged; idles cross as zeros.
// - repeater suppresses carrier sense during transmit.
// - alignment strap or bit 12 selects serializer-only.
// - serializer-only sends raw 5-bit transmit words.
// - serializer-only deserializes into raw 5-bit words.
// - serializer-only leaves all data, idles included, unaltered.
// - scrambler strap or bit 13 skips scrambling.
// - low power strap disables 10M and negotiation.
// - full power allows speed switching by management.
// - 32 word registers; control 00h, bypass 18h.
// - straps relatched on any reset within 2us.
`timescale 1ns/1ps
module pbm_datapath (
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire pbm_pkg::pbm_mii_tx_s mii_tx,
    output pbm_pkg::pbm_mii_rx_s mii_rx,
    output logic mii_tx_strobe,
    output logic mii_rx_strobe,
    input wire logic link_clk,
    input wire logic link_rxd,
    output logic link_txd,
    input wire logic strap_symbol_translate_bypass,
    input wire logic strap_scrambler_bypass,
    input wire logic strap_conditioning_bypass,
    input wire logic strap_repeater,
    input wire logic low_power_strap,
    input wire logic an_result_100,
    input wire logic [4:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    input wire logic mgmt_we,
    input wire logic mgmt_re,
    output logic [15:0] mgmt_rdata,
    output logic speed_100,
    output logic ten_meg_enable,
    output logic autoneg_enable
);
    localparam pbm_pkg::pbm_state_s ST_RESET = '{
        ctrl: pbm_pkg::CTRL_RESET_VAL,
        lbe: pbm_pkg::LBE_RESET_VAL,
        latch_cnt: pbm_pkg::STRAP_CYCLES,
        tx_sh: pbm_pkg::SYM_IDLE,
        tx_st: pbm_pkg::TXS_IDLE,
        rx_out: '0,
        default: '0
    };

    pbm_pkg::pbm_state_s st_reg;
    pbm_pkg::pbm_state_s st_next;

    logic lrise;
    logic serialize;
    logic transparent;
    logic scramble_on;
    logic [4:0] tx_sym;
    logic tx_bit;
    logic tx_sbit;
    logic rx_bit;
    logic rx_dbit;
    logic [9:0] rx10;
    logic jk_hit;
    logic [4:0] sym_o;
    logic [3:0] dec_nib;
    logic dec_valid;

    pbm_symbol_decode u_decode (
        .sym(sym_o),
        .nib(dec_nib),
        .valid(dec_valid)
    );

    always_comb begin
        serialize = st_reg.lbe[pbm_pkg::LBE_ALIGN_BYPASS_BIT];
        transparent = ~serialize & st_reg.lbe[pbm_pkg::LBE_SYM_BYPASS_BIT];
        scramble_on = ~serialize & ~st_reg.lbe[pbm_pkg::LBE_SCR_BYPASS_BIT];
        lrise = st_reg.sync2[pbm_pkg::SYNC_LCLK] & ~st_reg.lclk_prev;

        // next transmit code-group
        tx_sym = pbm_pkg::SYM_IDLE;
        if (serialize) begin
            tx_sym = {mii_tx.tx_er, mii_tx.txd};
        end else if (transparent) begin
            tx_sym = {mii_tx.tx_er, mii_tx.txd};
            if (tx_sym == pbm_pkg::SYM_ZERO) begin
                tx_sym = pbm_pkg::SYM_IDLE;
            end
        end else begin
            case (st_reg.tx_st)
                pbm_pkg::TXS_IDLE: tx_sym = mii_tx.tx_en ? pbm_pkg::SYM_J : pbm_pkg::SYM_IDLE;
                pbm_pkg::TXS_K: tx_sym = pbm_pkg::SYM_K;
                pbm_pkg::TXS_DATA: begin
                    if (!mii_tx.tx_en) begin
                        tx_sym = pbm_pkg::SYM_T;
                    end else if (mii_tx.tx_er) begin
                        tx_sym = pbm_pkg::SYM_HALT;
                    end else begin
                        tx_sym = pbm_pkg::ENC_TABLE[mii_tx.txd];
                    end
                end
                pbm_pkg::TXS_R: tx_sym = pbm_pkg::SYM_R;
                default: tx_sym = pbm_pkg::SYM_IDLE;
            endcase
        end

        tx_bit = st_reg.tx_sh[pbm_pkg::SYM_W-1];
        tx_sbit = tx_bit ^ st_reg.tx_scr[pbm_pkg::SCR_TAP_A] ^ st_reg.tx_scr[pbm_pkg::SCR_TAP_B];
        rx_bit = st_reg.sync2[pbm_pkg::SYNC_LRXD];
        rx_dbit = scramble_on ? (rx_bit ^ st_reg.rx_scr[pbm_pkg::SCR_TAP_A] ^ st_reg.rx_scr[pbm_pkg::SCR_TAP_B])
                              : rx_bit;
        rx10 = {st_reg.rx_hist, rx_dbit};
        // hunt only between streams, never while raw serializing
        jk_hit = ~serialize & ~st_reg.rx_active & ~st_reg.rx_tail & (rx10 == {pbm_pkg::SYM_J, pbm_pkg::SYM_K});
        // output lags one code-group so J is still on hand at K
        sym_o = jk_hit ? rx10[9:5] : st_reg.rx_pend;

        st_next = st_reg;
        st_next.sync1 = {low_power_strap, strap_repeater, strap_conditioning_bypass,
                         strap_scrambler_bypass, strap_symbol_translate_bypass, link_rxd, link_clk};
        st_next.sync2 = st_reg.sync1;
        st_next.lclk_prev = st_reg.sync2[pbm_pkg::SYNC_LCLK];
        st_next.tx_strobe = 1'b0;
        st_next.rx_strobe = 1'b0;
        st_next.low_power = st_reg.sync2[pbm_pkg::SYNC_LOW_POWER_STRAP];

        if (lrise) begin
            if (scramble_on) begin
                st_next.txd_bit = tx_sbit;
                st_next.tx_scr = {st_reg.tx_scr[pbm_pkg::SCR_LEN-2:0], tx_sbit};
                st_next.rx_scr = {st_reg.rx_scr[pbm_pkg::SCR_LEN-2:0], rx_bit};
            end else begin
                st_next.txd_bit = tx_bit;
            end

            // one strobe per code-group in every mode
            if (st_reg.tx_cnt == pbm_pkg::SYM_LAST) begin
                st_next.tx_cnt = 3'h0;
                st_next.tx_sh = tx_sym;
                st_next.tx_strobe = 1'b1;
                case (st_reg.tx_st)
                    pbm_pkg::TXS_IDLE: st_next.tx_st = (mii_tx.tx_en && !serialize && !transparent) ?
                                                       pbm_pkg::TXS_K : pbm_pkg::TXS_IDLE;
                    pbm_pkg::TXS_K: st_next.tx_st = pbm_pkg::TXS_DATA;
                    pbm_pkg::TXS_DATA: st_next.tx_st = mii_tx.tx_en ? pbm_pkg::TXS_DATA : pbm_pkg::TXS_R;
                    pbm_pkg::TXS_R: st_next.tx_st = pbm_pkg::TXS_IDLE;
                    default: st_next.tx_st = pbm_pkg::TXS_IDLE;
                endcase
            end else begin
                st_next.tx_cnt = st_reg.tx_cnt + 3'h1;
                st_next.tx_sh = {st_reg.tx_sh[3:0], 1'b0};
            end

            st_next.rx_hist = rx10[8:0];
            if (jk_hit || st_reg.rx_cnt == pbm_pkg::SYM_LAST) begin
                st_next.rx_cnt = 3'h0;
                st_next.rx_strobe = 1'b1;
                st_next.rx_pend = rx10[4:0];
                st_next.rx_out.rx_dv = 1'b0;
                st_next.rx_out.rx_er = 1'b0;
                st_next.rx_out.rxd = 4'h0;
                if (serialize) begin
                    {st_next.rx_out.rx_er, st_next.rx_out.rxd} = sym_o;
                end else if (jk_hit || st_reg.rx_active) begin
                    if (sym_o == pbm_pkg::SYM_T) begin
                        st_next.rx_active = 1'b0;
                        st_next.rx_tail = 1'b1;
                        if (transparent) begin
                            {st_next.rx_out.rx_er, st_next.rx_out.rxd} = sym_o;
                        end
                    end else if (sym_o == pbm_pkg::SYM_IDLE) begin
                        st_next.rx_active = 1'b0;
                    end else begin
                        st_next.rx_active = 1'b1;
                        // same valid flag in both modes
                        st_next.rx_out.rx_dv = 1'b1;
                        if (transparent) begin
                            {st_next.rx_out.rx_er, st_next.rx_out.rxd} = sym_o;
                        end else if (sym_o == pbm_pkg::SYM_J || sym_o == pbm_pkg::SYM_K) begin
                            st_next.rx_out.rxd = pbm_pkg::PREAMBLE_NIB;
                        end else begin
                            st_next.rx_out.rxd = dec_nib;
                            st_next.rx_out.rx_er = ~dec_valid;
                        end
                    end
                end else if (st_reg.rx_tail) begin
                    st_next.rx_tail = 1'b0;
                    if (transparent) begin
                        {st_next.rx_out.rx_er, st_next.rx_out.rxd} = sym_o;
                    end
                end
                // idle leaves the outputs at zero
            end else begin
                st_next.rx_cnt = st_reg.rx_cnt + 3'h1;
            end
        end

        // own transmit hidden in repeater mode
        st_next.rx_out.crs = (~serialize & (st_next.rx_active | st_next.rx_tail)) |
                             (mii_tx.tx_en & ~st_reg.repeater);
        st_next.rx_out.col = ~serialize & mii_tx.tx_en & st_next.rx_active;

        if (mgmt_re) begin
            case (mgmt_addr)
                pbm_pkg::REG_CONTROL: st_next.rdata = st_reg.ctrl;
                pbm_pkg::REG_LOOPBACK_BYPASS: st_next.rdata = st_reg.lbe;
                default: st_next.rdata = 16'h0000;
            endcase
        end

        if (st_reg.latch_cnt != 5'h00) begin
            st_next.latch_cnt = st_reg.latch_cnt - 5'h01;
            st_next.lbe[pbm_pkg::LBE_SYM_BYPASS_BIT] = st_reg.sync2[pbm_pkg::SYNC_SYM];
            st_next.lbe[pbm_pkg::LBE_SCR_BYPASS_BIT] = st_reg.sync2[pbm_pkg::SYNC_SCR];
            st_next.lbe[pbm_pkg::LBE_ALIGN_BYPASS_BIT] = st_reg.sync2[pbm_pkg::SYNC_ALIGN];
            st_next.repeater = st_reg.sync2[pbm_pkg::SYNC_REP];
            if (st_reg.latch_cnt == pbm_pkg::LATCH_LAST) begin
                st_next.ctrl[pbm_pkg::CTRL_RESET_BIT] = 1'b0;
            end
        end else if (mgmt_we) begin
            // writes during the capture window are dropped so defaults cannot be torn
            case (mgmt_addr)
                pbm_pkg::REG_CONTROL: begin
                    if (mgmt_wdata[pbm_pkg::CTRL_RESET_BIT]) begin
                        st_next = ST_RESET;
                        st_next.sync1 = st_reg.sync1;
                        st_next.sync2 = st_reg.sync2;
                        st_next.lclk_prev = st_reg.lclk_prev;
                        st_next.low_power = st_reg.low_power;
                        st_next.ctrl[pbm_pkg::CTRL_RESET_BIT] = 1'b1;
                    end else begin
                        st_next.ctrl = mgmt_wdata;
                    end
                end
                pbm_pkg::REG_LOOPBACK_BYPASS: st_next.lbe = mgmt_wdata;
                default: st_next.ctrl = st_reg.ctrl;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg <= ST_RESET;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign mii_rx = st_reg.rx_out;
    assign mii_tx_strobe = st_reg.tx_strobe;
    assign mii_rx_strobe = st_reg.rx_strobe;
    assign link_txd = st_reg.txd_bit;
    assign mgmt_rdata = st_reg.rdata;
    assign speed_100 = st_reg.low_power |
                       (st_reg.ctrl[pbm_pkg::CTRL_AN_BIT] ? an_result_100 : st_reg.ctrl[pbm_pkg::CTRL_SPEED_BIT]);
    assign ten_meg_enable = ~st_reg.low_power;
    assign autoneg_enable = ~st_reg.low_power & st_reg.ctrl[pbm_pkg::CTRL_AN_BIT];
endmodule

// ===== test/pbm_link_model.sv
// serial link partner: free-running bit clock, receive stream, transmit capture
// assumes the bench queues 5-bit symbols, sent most significant bit first
`timescale 1ns/1ps
module pbm_link_model (
    output logic link_clk,
    output logic link_rxd,
    input wire logic link_txd
);
    logic [4:0] q[$];
    logic [4:0] cur = 5'h1f;
    logic [4:0] tx_hist = 5'h00;
    int bitn = 4;
    initial begin
        link_clk = 1'b0;
        link_rxd = 1'b1;
        // odd phase keeps link edges off the core clock edges
        #37;
        forever #400 link_clk = ~link_clk;
    end
    // idle groups fill every gap, as on a live line
    always @(negedge link_clk) begin
        link_rxd <= cur[bitn];
        if (bitn == 0) begin
            bitn = 4;
            cur = (q.size() > 0) ? q.pop_front() : 5'h1f;
        end else begin
            bitn--;
        end
    end
    always @(posedge link_clk) begin
        tx_hist <= {tx_hist[3:0], link_txd};
    end
endmodule

// ===== test/pbm_datapath_asserts.sv
// port checks for the bypass datapath
// assumes one core clock domain with synchronous active-low reset
`timescale 1ns/1ps
module pbm_datapath_asserts (
    input wire logic clock,
    input wire logic nrst,
    input wire pbm_pkg::pbm_mii_tx_s mii_tx,
    input wire pbm_pkg::pbm_mii_rx_s mii_rx,
    input wire logic mii_tx_strobe,
    input wire logic mii_rx_strobe,
    input wire logic link_clk,
    input wire logic link_txd,
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_we,
    input wire logic mgmt_re,
    input wire logic [15:0] mgmt_rdata
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    tx_spacing_a: assert property (mii_tx_strobe |=> !mii_tx_strobe [*8])
        else $error("transmit strobe repeated too soon");
    rx_spacing_a: assert property (mii_rx_strobe |=> !mii_rx_strobe [*6])
        else $error("receive strobe repeated too soon");
    // writes excluded: a software reset may clear outputs
    rx_hold_a: assert property (!mii_rx_strobe && !$past(mgmt_we) && !$past(mgmt_we, 2)
        |-> $stable({mii_rx.rx_dv, mii_rx.rx_er, mii_rx.rxd}))
        else $error("receive word changed without strobe");
    rdata_hold_a: assert property (!mgmt_re && !mgmt_we && !$past(mgmt_we) |=> $stable(mgmt_rdata))
        else $error("read data changed without read");
    unmapped_zero_a: assert property (mgmt_re && !mgmt_we && mgmt_addr != 5'h00 && mgmt_addr != 5'h18
        |=> mgmt_rdata == 16'h0000)
        else $error("unmapped read not zero");
    col_idle_a: assert property (!mii_tx.tx_en && !$past(mii_tx.tx_en) |-> !mii_rx.col)
        else $error("collision without transmit");
    tx_rise_a: assert property (mii_tx_strobe |-> $past(link_clk, 2) || $past(link_clk, 3) || $past(link_clk, 4))
        else $error("transmit strobe away from link rise");
    txd_rise_a: assert property ($changed(link_txd) && !$past(mgmt_we) && !$past(mgmt_we, 2)
        |-> $past(link_clk) || $past(link_clk, 2) || $past(link_clk, 3))
        else $error("serial bit changed away from link rise");
endmodule
bind pbm_datapath pbm_datapath_asserts u_asserts (.clock, .nrst, .mii_tx, .mii_rx, .mii_tx_strobe,
    .mii_rx_strobe, .link_clk, .link_txd, .mgmt_addr, .mgmt_we, .mgmt_re, .mgmt_rdata);

// ===== test/test_pbm_datapath.sv
// self-checking bench for the bypass datapath
// assumes link model and checker compiled first; inputs change at falling edges
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module test_pbm_datapath;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    pbm_pkg::pbm_mii_tx_s mii_tx = '0;
    pbm_pkg::pbm_mii_rx_s mii_rx;
    logic tx_stb, rx_stb, link_clk, link_rxd, link_txd, spd, ten, an_en;
    logic s_sym = 1'b0, s_scr = 1'b0, s_al = 1'b0, s_rep = 1'b0, s_lp = 1'b0, an100 = 1'b0;
    logic [4:0] addr = '0;
    logic [4:0] cap;
    logic [15:0] wdata = '0, rdata, rv;
    logic we = 1'b0, re = 1'b0, ce = 1'b1;
    int fail_count = 0, cmp_count = 0;
    always #50 clock = ~clock;
    pbm_datapath u_dut (.clock(clock), .nrst(nrst), .ce(ce), .mii_tx(mii_tx), .mii_rx(mii_rx),
        .mii_tx_strobe(tx_stb), .mii_rx_strobe(rx_stb), .link_clk(link_clk), .link_rxd(link_rxd),
        .link_txd(link_txd), .strap_symbol_translate_bypass(s_sym), .strap_scrambler_bypass(s_scr),
        .strap_conditioning_bypass(s_al), .strap_repeater(s_rep), .low_power_strap(s_lp),
        .an_result_100(an100), .mgmt_addr(addr), .mgmt_wdata(wdata), .mgmt_we(we), .mgmt_re(re),
        .mgmt_rdata(rdata), .speed_100(spd), .ten_meg_enable(ten), .autoneg_enable(an_en));
    pbm_link_model u_link (.link_clk(link_clk), .link_rxd(link_rxd), .link_txd(link_txd));
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    // 25 cycles covers the strap capture window
    task automatic do_reset();
        nrst = 1'b0;
        cyc(20);
        nrst = 1'b1;
        cyc(25);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        cyc(1);
        we = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        addr = a;
        re = 1'b1;
        cyc(1);
        re = 1'b0;
        rv = rdata;
    endtask
    task automatic strobe_wait(ref logic s);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (s !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    // bits of the sampled word land on the next five link rises
    task automatic tx_send(input logic [5:0] t);
        @(negedge clock);
        mii_tx = t;
        strobe_wait(tx_stb);
        repeat (6) @(posedge link_clk);
        #1;
        cap = u_link.tx_hist;
        // realign to a falling edge so the next strobe task is sampled
        @(negedge clock);
    endtask
    task automatic rx_sync();
        int n;
        n = 0;
        strobe_wait(rx_stb);
        while (mii_rx.rx_dv !== 1'b1 && n < 20) begin
            strobe_wait(rx_stb);
            n++;
        end
    endtask
    task automatic t_regs();
        rd(5'h00);
        `CHK(rv, 16'h3000);
        rd(5'h18);
        `CHK(rv, 16'h0000);
        rd(5'h01);
        `CHK(rv, 16'h0000);
        wr(5'h18, 16'h4000);
        rd(5'h18);
        `CHK(rv, 16'h4000);
        // frozen clock enable must swallow the write
        ce = 1'b0;
        wr(5'h18, 16'h0000);
        ce = 1'b1;
        rd(5'h18);
        `CHK(rv, 16'h4000);
        wr(5'h00, 16'h0000);
        `CHK(spd, 1'b0);
        wr(5'h00, 16'h2000);
        `CHK(spd, 1'b1);
        wr(5'h00, 16'h1000);
        `CHK(spd, 1'b0);
        an100 = 1'b1;
        cyc(1);
        `CHK(spd, 1'b1);
        `CHK(an_en, 1'b1);
        wr(5'h00, 16'h3000);
    endtask
    task automatic t_tx_modes();
        wr(5'h18, 16'h6000);
        tx_send(6'h00);
        `CHK(cap, 5'h1f);
        tx_send(6'h38);
        `CHK(cap, 5'h18);
        tx_send(6'h00);
        wr(5'h18, 16'h7000);
        tx_send(6'h00);
        `CHK(cap, 5'h00);
        tx_send(6'h35);
        `CHK(cap, 5'h15);
        tx_send(6'h00);
        wr(5'h18, 16'h2000);
        tx_send(6'h00);
        tx_send(6'h23);
        `CHK(cap, pbm_pkg::SYM_J);
        tx_send(6'h00);
        `CHK(cap, pbm_pkg::SYM_T);
    endtask
    task automatic t_rx_transparent();
        wr(5'h18, 16'h6000);
        u_link.q = '{pbm_pkg::SYM_J, pbm_pkg::SYM_K, 5'h0e, 5'h15, pbm_pkg::SYM_T, pbm_pkg::SYM_R};
        rx_sync();
        `CHK({mii_rx.rx_er, mii_rx.rxd}, pbm_pkg::SYM_J);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_er, mii_rx.rxd}, pbm_pkg::SYM_K);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_dv, mii_rx.rx_er, mii_rx.rxd}, 6'h2e);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_er, mii_rx.rxd}, 5'h15);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_dv, mii_rx.rx_er, mii_rx.rxd}, {1'b0, pbm_pkg::SYM_T});
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_er, mii_rx.rxd}, pbm_pkg::SYM_R);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_er, mii_rx.rxd}, 5'h00);
        cyc(1);
    endtask
    task automatic t_rx_translate();
        wr(5'h18, 16'h2000);
        u_link.q = '{pbm_pkg::SYM_J, pbm_pkg::SYM_K, pbm_pkg::ENC_TABLE[3], pbm_pkg::ENC_TABLE[10],
            pbm_pkg::SYM_T, pbm_pkg::SYM_R};
        rx_sync();
        `CHK(mii_rx.rxd, pbm_pkg::PREAMBLE_NIB);
        strobe_wait(rx_stb);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_dv, mii_rx.rx_er, mii_rx.rxd}, 6'h23);
        strobe_wait(rx_stb);
        `CHK({mii_rx.rx_dv, mii_rx.rx_er, mii_rx.rxd}, 6'h2a);
        strobe_wait(rx_stb);
        `CHK(mii_rx.rx_dv, 1'b0);
        cyc(100);
    endtask
    task automatic t_soft_reset();
        wr(5'h18, 16'h4000);
        wr(5'h00, 16'h8000);
        rd(5'h00);
        `CHK(rv, 16'hb000);
        cyc(25);
        rd(5'h18);
        `CHK(rv, 16'h0000);
        rd(5'h00);
        `CHK(rv, 16'h3000);
    endtask
    task automatic t_straps();
        {s_lp, s_al, s_sym, s_scr, s_rep} = 5'h1f;
        do_reset();
        rd(5'h18);
        `CHK(rv, 16'h7000);
        `CHK({ten, an_en}, 2'b00);
        mii_tx = 6'h20;
        cyc(3);
        `CHK(mii_rx.crs, 1'b0);
        mii_tx = 6'h00;
        {s_lp, s_al, s_sym, s_scr, s_rep} = 5'h00;
        do_reset();
        mii_tx = 6'h20;
        cyc(3);
        `CHK(mii_rx.crs, 1'b1);
        mii_tx = 6'h00;
    endtask
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_regs();
        t_tx_modes();
        t_rx_transparent();
        t_rx_translate();
        t_soft_reset();
        t_straps();
        summarize();
    end
    initial begin
        #1000000;
        fail_count++;
        summarize();
    end
endmodule
